// File: sfm_framer.sv
`timescale 1ns/1ps
module sfm_framer
  import sfm_pkg::*;
#(
  parameter logic [BITS_W-1:0] FRAME_BITS = FRAME_BITS_DEF,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic smp_valid,
  output logic smp_ready,
  output logic [FRM_IDX_W-1:0] cur_frame,
  output logic sf_pending,
  input wire logic req_valid,
  input wire logic [QUAD_W-1:0] req_quad,
  output logic req_ready,
  output logic reject,
  output logic [REJ_W-1:0] reject_count,
  output logic [QUAD_W-1:0] active_quad,
  output logic frm_valid,
  input wire logic frm_ready,
  output logic [FRM_IDX_W-1:0] frm_index,
  output logic [1:0] frm_mode,
  output logic [SUP_W-1:0] frm_support,
  output logic [LA_W-1:0] frm_lookahead,
  output logic frm_block_start,
  output logic frm_block_end,
  output logic frm_super_end,
  output logic [BITS_W-1:0] frm_bits
);
  typedef enum logic {
    ST_WAIT,
    ST_EMIT
  } sfm_state_t;

  function automatic logic [SUP_W-1:0] support_of(sfm_mode_t m);
    unique case (m)
      PREDICTIVE_FRAME_MODE: return SUP_256;
      TRANSFORM_256_MODE: return SUP_256;
      TRANSFORM_512_MODE: return SUP_512;
      TRANSFORM_1024_MODE: return SUP_1024;
    endcase
  endfunction

  // the predictive mode needs no transform overlap
  function automatic logic [LA_W-1:0] lookahead_of(sfm_mode_t m);
    unique case (m)
      PREDICTIVE_FRAME_MODE: return LA_NONE;
      TRANSFORM_256_MODE: return LA_T256;
      TRANSFORM_512_MODE: return LA_T512;
      TRANSFORM_1024_MODE: return LA_T1024;
    endcase
  endfunction

  sfm_stream_if #(.W(FRAME_W)) push_if ();

  logic quad_legal;
  logic buf_valid;
  logic [FRAME_W-1:0] buf_data;
  sfm_frame_t head;

  sfm_mode_check u_check (
    .quad(req_quad),
    .legal(quad_legal)
  );

  sfm_skid_buf #(.W(FRAME_W), .DEPTH(DEPTH)) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_if(push_if.snk),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(frm_ready)
  );

  // sample side
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic pend_q;
  logic pend_d;
  logic smp_ready_q;
  logic smp_ready_d;
  // request side
  sfm_state_t state_q;
  sfm_state_t state_d;
  logic req_ready_q;
  logic req_ready_d;
  logic reject_q;
  logic reject_d;
  logic [REJ_W-1:0] rej_cnt_q;
  logic [REJ_W-1:0] rej_cnt_d;
  logic [QUAD_W-1:0] quad_q;
  logic [QUAD_W-1:0] quad_d;
  logic [FRM_IDX_W-1:0] k_q;
  logic [FRM_IDX_W-1:0] k_d;

  logic smp_take;
  logic sf_done;
  logic req_take;
  logic accept;
  logic emit_push;

  assign smp_take = smp_valid && smp_ready_q;
  assign sf_done = smp_take && (cnt_q == SF_LAST);
  assign req_take = req_valid && req_ready_q;
  assign accept = req_take && quad_legal;
  assign emit_push = push_if.valid && push_if.ready;

  // sample counting; a finished super-frame waits for its quadruplet
  always_comb begin
    cnt_d = cnt_q;
    pend_d = pend_q;
    if (smp_take) begin
      cnt_d = CNT_W'(cnt_q + 1'b1);
    end
    if (accept) begin
      pend_d = 1'b0;
    end
    // a completion in the same cycle as an accept is kept
    if (sf_done) begin
      pend_d = 1'b1;
    end
    // hold the last sample back rather than overrun an unserved super-frame
    smp_ready_d = !(pend_d && (cnt_d == SF_LAST));
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      pend_q <= 1'b0;
      smp_ready_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      smp_ready_q <= smp_ready_d;
    end
  end

  // quadruplet intake and per-frame emission
  always_comb begin
    state_d = state_q;
    quad_d = quad_q;
    k_d = k_q;
    reject_d = 1'b0;
    rej_cnt_d = rej_cnt_q;
    unique case (state_q)
      ST_WAIT: begin
        if (req_take) begin
          if (quad_legal) begin
            quad_d = req_quad;
            k_d = '0;
            state_d = ST_EMIT;
          end else begin
            reject_d = 1'b1;
            if (rej_cnt_q != '1) begin
              rej_cnt_d = REJ_W'(rej_cnt_q + 1'b1);
            end
          end
        end
      end
      ST_EMIT: begin
        // buffer back-pressure holds the frame index where it is
        if (emit_push) begin
          k_d = FRM_IDX_W'(k_q + 1'b1);
          if (k_q == FRM_IDX_W'(FRAMES - 1)) begin
            state_d = ST_WAIT;
          end
        end
      end
    endcase
    req_ready_d = (state_d == ST_WAIT) && pend_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_WAIT;
      quad_q <= '0;
      k_q <= '0;
      reject_q <= 1'b0;
      rej_cnt_q <= '0;
      req_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      quad_q <= quad_d;
      k_q <= k_d;
      reject_q <= reject_d;
      rej_cnt_q <= rej_cnt_d;
      req_ready_q <= req_ready_d;
    end
  end

  // descriptor of the transmitted frame now being emitted
  always_comb begin
    sfm_frame_t f;
    sfm_mode_t m;
    f = '0;
    m = sfm_mode_of(quad_q, k_q);
    f.index = k_q;
    f.mode = m;
    f.support = support_of(m);
    f.lookahead = lookahead_of(m);
    f.bits = FRAME_BITS;
    f.super_end = (k_q == FRM_IDX_W'(FRAMES - 1));
    unique case (m)
      TRANSFORM_512_MODE: begin
        f.block_start = !k_q[0];
        f.block_end = k_q[0];
      end
      TRANSFORM_1024_MODE: begin
        f.block_start = (k_q == '0);
        f.block_end = f.super_end;
      end
      default: begin
        f.block_start = 1'b1;
        f.block_end = 1'b1;
      end
    endcase
    push_if.data = f;
    push_if.valid = (state_q == ST_EMIT);
  end

  assign head = sfm_frame_t'(buf_data);
  assign smp_ready = smp_ready_q;
  assign cur_frame = cnt_q[CNT_W-1 -: FRM_IDX_W];
  assign sf_pending = pend_q;
  assign req_ready = req_ready_q;
  assign reject = reject_q;
  assign reject_count = rej_cnt_q;
  assign active_quad = quad_q;
  assign frm_valid = buf_valid;
  assign frm_index = head.index;
  assign frm_mode = head.mode;
  assign frm_support = head.support;
  assign frm_lookahead = head.lookahead;
  assign frm_block_start = head.block_start;
  assign frm_block_end = head.block_end;
  assign frm_super_end = head.super_end;
  assign frm_bits = head.bits;
endmodule

// File: sfm_pkg.sv
package sfm_pkg;
  // super-frame geometry, in samples at half the internal sample rate
  localparam int SF_LEN = 1024;
  localparam int FRM_LEN = 256;
  localparam int FRAMES = 4;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] SF_LAST = CNT_W'(SF_LEN - 1);
  localparam int FRM_IDX_W = 2;
  // transform supports and look-ahead
  localparam int SUP_W = 11;
  localparam int LA_W = 8;
  localparam logic [SUP_W-1:0] SUP_256 = 11'h100;
  localparam logic [SUP_W-1:0] SUP_512 = 11'h200;
  localparam logic [SUP_W-1:0] SUP_1024 = 11'h400;
  localparam logic [LA_W-1:0] LA_NONE = 8'h00;
  localparam logic [LA_W-1:0] LA_T256 = 8'h20;
  localparam logic [LA_W-1:0] LA_T512 = 8'h40;
  localparam logic [LA_W-1:0] LA_T1024 = 8'h80;
  // size of the legal quadruplet set
  localparam int LEGAL_QUADS = 26;
  localparam int QUAD_W = 8;
  localparam int BITS_W = 12;
  localparam logic [BITS_W-1:0] FRAME_BITS_DEF = 12'h100;
  localparam int REJ_W = 8;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    PREDICTIVE_FRAME_MODE = 2'h0,
    TRANSFORM_256_MODE = 2'h1,
    TRANSFORM_512_MODE = 2'h2,
    TRANSFORM_1024_MODE = 2'h3
  } sfm_mode_t;

  typedef struct packed {
    logic [FRM_IDX_W-1:0] index;
    sfm_mode_t mode;
    logic [SUP_W-1:0] support;
    logic [LA_W-1:0] lookahead;
    logic block_start;
    logic block_end;
    logic super_end;
    logic [BITS_W-1:0] bits;
  } sfm_frame_t;

  localparam int FRAME_W = $bits(sfm_frame_t);

  function automatic sfm_mode_t sfm_mode_of(logic [QUAD_W-1:0] quad,
                                            logic [FRM_IDX_W-1:0] k);
    return sfm_mode_t'(quad[2*k +: 2]);
  endfunction
endpackage

// File: sfm_stream_if.sv
`timescale 1ns/1ps
interface sfm_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: sfm_mode_check.sv
`timescale 1ns/1ps
module sfm_mode_check
  import sfm_pkg::*;
(
  input wire logic [QUAD_W-1:0] quad,
  output logic legal
);
  // one half of the super-frame: two single frames, or one paired block
  function automatic logic half_ok(sfm_mode_t a, sfm_mode_t b);
    logic single_a;
    logic single_b;
    single_a = (a == PREDICTIVE_FRAME_MODE) || (a == TRANSFORM_256_MODE);
    single_b = (b == PREDICTIVE_FRAME_MODE) || (b == TRANSFORM_256_MODE);
    if (a == TRANSFORM_512_MODE) begin
      return b == TRANSFORM_512_MODE;
    end
    return single_a && single_b;
  endfunction

  always_comb begin
    logic full;
    full = 1'b1;
    for (int k = 0; k < FRAMES; k++) begin
      if (sfm_mode_of(quad, FRM_IDX_W'(k)) != TRANSFORM_1024_MODE) begin
        full = 1'b0;
      end
    end
    // 5 x 5 half combinations plus the all-1024 case give the legal set
    legal = full || (half_ok(sfm_mode_of(quad, 2'h0), sfm_mode_of(quad, 2'h1))
      && half_ok(sfm_mode_of(quad, 2'h2), sfm_mode_of(quad, 2'h3)));
  end
endmodule

// File: sfm_skid_buf.sv
`timescale 1ns/1ps
module sfm_skid_buf
  import sfm_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  sfm_stream_if.snk in_if,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  // head always sits in entry 0 so the outputs come straight from flops
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];

  assign in_if.ready = !vld_q[DEPTH-1];
  assign out_valid = vld_q[0];
  assign out_data = mem_q[0];

  always_comb begin
    logic placed;
    placed = 1'b0;
    vld_d = vld_q;
    mem_d = mem_q;
    if (out_ready && vld_q[0]) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        vld_d[i] = vld_q[i + 1];
        mem_d[i] = mem_q[i + 1];
      end
      vld_d[DEPTH-1] = 1'b0;
    end
    if (in_if.valid && in_if.ready) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !vld_d[i]) begin
          vld_d[i] = 1'b1;
          mem_d[i] = in_if.data;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      vld_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      vld_q <= vld_d;
      mem_q <= mem_d;
    end
  end
endmodule

// File: sfm_framer_asserts.sv
`timescale 1ns/1ps
module sfm_framer_asserts
  import sfm_pkg::*;
#(
  parameter logic [BITS_W-1:0] FRAME_BITS = FRAME_BITS_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic [QUAD_W-1:0] req_quad,
  input wire logic req_ready,
  input wire logic reject,
  input wire logic [QUAD_W-1:0] active_quad,
  input wire logic frm_valid,
  input wire logic frm_ready,
  input wire logic [FRM_IDX_W-1:0] frm_index,
  input wire logic [1:0] frm_mode,
  input wire logic [SUP_W-1:0] frm_support,
  input wire logic [LA_W-1:0] frm_lookahead,
  input wire logic frm_block_start,
  input wire logic frm_block_end,
  input wire logic frm_super_end,
  input wire logic [BITS_W-1:0] frm_bits
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire take = req_valid && req_ready;
  // halves are two of {0,1} or (2,2); only all-3 may use 3
  function automatic logic ok(logic [7:0] q);
    return q == 8'hff || ((q[3:0] == 4'ha || !(q[3] | q[1])) &&
      (q[7:4] == 4'ha || !(q[7] | q[5])));
  endfunction
  a_reject_cause: assert property (
    reject |-> $past(take) && !ok($past(req_quad)))
    else $error("reject without an illegal request");
  a_refuse_illegal: assert property (
    take && !ok(req_quad) |=> reject && req_ready)
    else $error("illegal quadruplet not refused");
  a_accept_legal: assert property (
    take && ok(req_quad) |=> !req_ready && !reject &&
      active_quad == $past(req_quad))
    else $error("legal quadruplet not accepted");
  a_quad_legal: assert property (ok(active_quad))
    else $error("active quadruplet illegal");
  a_t256_shape: assert property (
    frm_valid && frm_mode == 2'h1 |->
      frm_support == SUP_256 && frm_lookahead == LA_T256)
    else $error("short transform frame shape wrong");
  a_t512_shape: assert property (
    frm_valid && frm_mode == 2'h2 |-> frm_support == SUP_512 &&
      frm_lookahead == LA_T512 && frm_block_start == !frm_index[0])
    else $error("pair transform frame shape wrong");
  a_t1024_shape: assert property (
    frm_valid && frm_mode == 2'h3 |-> frm_support == SUP_1024 &&
      frm_lookahead == LA_T1024 && frm_block_start == (frm_index == 2'h0))
    else $error("full transform frame shape wrong");
  a_block_end_mark: assert property (
    frm_valid |-> frm_block_end == ((frm_mode == 2'h2) ? frm_index[0] :
      (frm_mode == 2'h3) ? (frm_index == 2'h3) : 1'b1))
    else $error("block end mark wrong");
  a_equal_size: assert property (
    frm_valid |-> frm_bits == FRAME_BITS &&
      frm_super_end == (frm_index == 2'h3))
    else $error("frame size or end mark wrong");
  a_head_held: assert property (
    frm_valid && !frm_ready |=> frm_valid && $stable(frm_index) &&
      $stable(frm_mode))
    else $error("stalled head changed");
  a_frame_order: assert property (
    (frm_valid && frm_ready && frm_index != 2'h3) ##1 frm_valid |->
      frm_index == $past(frm_index) + 2'h1)
    else $error("frames out of order");
endmodule

bind sfm_framer sfm_framer_asserts #(.FRAME_BITS(FRAME_BITS)) u_chk (
  .clock(clock),
  .sys_rst(sys_rst),
  .req_valid(req_valid),
  .req_quad(req_quad),
  .req_ready(req_ready),
  .reject(reject),
  .active_quad(active_quad),
  .frm_valid(frm_valid),
  .frm_ready(frm_ready),
  .frm_index(frm_index),
  .frm_mode(frm_mode),
  .frm_support(frm_support),
  .frm_lookahead(frm_lookahead),
  .frm_block_start(frm_block_start),
  .frm_block_end(frm_block_end),
  .frm_super_end(frm_super_end),
  .frm_bits(frm_bits)
);

// File: sfm_sink_model.sv
`timescale 1ns/1ps
module sfm_sink_model
  import sfm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [FRM_IDX_W-1:0] frm_index,
  input wire logic [1:0] frm_mode,
  input wire logic frm_super_end,
  output logic [QUAD_W-1:0] rx_quad,
  output int rx_sf
);
  logic [1:0] ph;
  logic [QUAD_W-1:0] acc;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= 2'h0;
      frm_ready <= 1'b0;
      acc <= 8'h00;
      rx_quad <= 8'h00;
      rx_sf <= 0;
    end else begin
      ph <= ph + 2'h1;
      // slow packer takes one cycle in four, to fill the buffer
      frm_ready <= !slow || ph == 2'h3;
      if (frm_valid && frm_ready) begin
        acc[2*frm_index +: 2] <= frm_mode;
        if (frm_super_end) begin
          rx_quad <= {frm_mode, acc[5:0]};
          rx_sf <= rx_sf + 1;
        end
      end
    end
  end
endmodule

// File: sfm_framer_tb.sv
`timescale 1ns/1ps
module sfm_framer_tb;
  import sfm_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic smp_valid = 1'b0;
  logic req_valid = 1'b0;
  logic [QUAD_W-1:0] req_quad = 8'h00;
  logic slow = 1'b0;
  logic smp_ready, sf_pending, req_ready, reject, frm_valid, frm_ready;
  logic frm_super_end;
  logic [REJ_W-1:0] reject_count;
  logic [QUAD_W-1:0] active_quad, rx_quad;
  logic [FRM_IDX_W-1:0] frm_index;
  logic [FRM_IDX_W-1:0] cur_frame;
  logic [1:0] frm_mode;
  int rx_sf;
  int n_errors = 0;
  int n_checks = 0;
  int n_good = 0;
  int n_bad = 0;

  always #4 clock = ~clock;

  sfm_framer uut (
    .clock(clock),
    .sys_rst(sys_rst),
    .smp_valid(smp_valid),
    .smp_ready(smp_ready),
    .cur_frame(cur_frame),
    .sf_pending(sf_pending),
    .req_valid(req_valid),
    .req_quad(req_quad),
    .req_ready(req_ready),
    .reject(reject),
    .reject_count(reject_count),
    .active_quad(active_quad),
    .frm_valid(frm_valid),
    .frm_ready(frm_ready),
    .frm_index(frm_index),
    .frm_mode(frm_mode),
    .frm_support(),
    .frm_lookahead(),
    .frm_block_start(),
    .frm_block_end(),
    .frm_super_end(frm_super_end),
    .frm_bits()
  );

  sfm_sink_model u_sink (
    .clock(clock),
    .sys_rst(sys_rst),
    .slow(slow),
    .frm_valid(frm_valid),
    .frm_ready(frm_ready),
    .frm_index(frm_index),
    .frm_mode(frm_mode),
    .frm_super_end(frm_super_end),
    .rx_quad(rx_quad),
    .rx_sf(rx_sf)
  );

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic half_ok(logic [1:0] a, logic [1:0] b);
    return (a < 2'h2 && b < 2'h2) || (a == 2'h2 && b == 2'h2);
  endfunction

  function automatic logic legal(logic [7:0] q);
    return q == 8'hff || (half_ok(q[1:0], q[3:2]) && half_ok(q[5:4], q[7:6]));
  endfunction

  task reset_values;
    chk(16'(smp_ready), 16'h1);
    chk(16'(req_ready), 16'h0);
    chk(16'(frm_valid), 16'h0);
    chk(16'(reject_count), 16'h0);
    chk(16'(cur_frame), 16'h0);
  endtask

  // a legal quadruplet must come back frame by frame at the packer
  task send(input logic [7:0] q);
    int i;
    int s;
    logic good;
    good = legal(q);
    i = 0;
    while (req_ready !== 1'b1 && i < 3000) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk(16'(sf_pending), 16'h1);
    @(posedge clock);
    req_valid <= 1'b1;
    req_quad <= q;
    slow <= q[0];
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    chk(16'(reject), 16'(!good));
    if (good) begin
      n_good++;
      chk(16'(active_quad), 16'(q));
      chk(16'(sf_pending), 16'h0);
      s = rx_sf;
      i = 0;
      while (rx_sf == s && i < 3000) begin
        @(posedge clock);
        #1;
        i++;
      end
      chk(16'(rx_quad), 16'(q));
      // receiver side: fixed grouping is what concealment would lean on
      chk(16'(legal(rx_quad)), 16'h1);
    end else begin
      n_bad++;
    end
  endtask

  task all_quads;
    for (int q = 0; q < 256; q++) begin
      send(q[7:0]);
    end
    chk(16'(n_good), 16'h1a);
    chk(16'(reject_count), 16'(n_bad));
  endtask

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    reset_values();
    @(posedge clock);
    smp_valid <= 1'b1;
    all_quads();
    end_of_test();
  end

  initial begin
    #600000;
    n_errors++;
    end_of_test();
  end
endmodule
